// *** dcm_ds0_monitor.sv ***
// DS0 channel monitor for both framers of a dual T1 framer.
// Assumes a synchronous 8-bit register port and bit-strobed serial paths.
`timescale 1ns/1ns
module dcm_ds0_monitor (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // Register port
    input wire logic [7:0] addr,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] wr_data,
    output logic [7:0] rd_data,
    // Framer A transmit path, backplane toward line
    input wire logic tx_a_bit_valid,
    input wire logic tx_a_bit,
    input wire logic tx_a_frame_sync,
    input wire logic [23:0] tx_a_replace_mask,
    input wire logic [7:0] tx_a_replace_code,
    output logic tx_a_out_bit,
    output logic tx_a_out_valid,
    // Framer A receive path, line toward backplane
    input wire logic rx_a_bit_valid,
    input wire logic rx_a_bit,
    input wire logic rx_a_frame_sync,
    input wire logic [23:0] rx_a_replace_mask,
    input wire logic [7:0] rx_a_replace_code,
    output logic rx_a_out_bit,
    output logic rx_a_out_valid,
    // Framer B transmit path
    input wire logic tx_b_bit_valid,
    input wire logic tx_b_bit,
    input wire logic tx_b_frame_sync,
    input wire logic [23:0] tx_b_replace_mask,
    input wire logic [7:0] tx_b_replace_code,
    output logic tx_b_out_bit,
    output logic tx_b_out_valid,
    // Framer B receive path
    input wire logic rx_b_bit_valid,
    input wire logic rx_b_bit,
    input wire logic rx_b_frame_sync,
    input wire logic [23:0] rx_b_replace_mask,
    input wire logic [7:0] rx_b_replace_code,
    output logic rx_b_out_bit,
    output logic rx_b_out_valid
);

    // ----------------------------------------
    // Select registers
    // ----------------------------------------
    logic [4:0] tx_sel_a_reg;
    logic [4:0] rx_sel_a_reg;
    logic [4:0] tx_sel_b_reg;
    logic [4:0] rx_sel_b_reg;
    logic [7:0] tx_snap_a;
    logic [7:0] rx_snap_a;
    logic [7:0] tx_snap_b;
    logic [7:0] rx_snap_b;
    logic [7:0] rd_data_next;
    logic wr_tx_a;
    logic wr_rx_a;
    logic wr_tx_b;
    logic wr_rx_b;
    logic [4:0] wr_sel;

    // Write decode; snapshot offsets take no write
    assign wr_tx_a = ce && wr_en && (addr == dcm_pkg::TX_MONITOR_SELECT_A_OFS);
    assign wr_rx_a = ce && wr_en && (addr == dcm_pkg::RX_MONITOR_SELECT_A_OFS);
    assign wr_tx_b = ce && wr_en && (addr == dcm_pkg::TX_MONITOR_SELECT_B_OFS);
    assign wr_rx_b = ce && wr_en && (addr == dcm_pkg::RX_MONITOR_SELECT_B_OFS);
    assign wr_sel = wr_data[dcm_pkg::SEL_MSB:dcm_pkg::SEL_LSB];

    // Select storage, upper bits not kept
    always_ff @(posedge clk) begin
        if (reset) begin
            tx_sel_a_reg <= dcm_pkg::SEL_RESET;
            rx_sel_a_reg <= dcm_pkg::SEL_RESET;
            tx_sel_b_reg <= dcm_pkg::SEL_RESET;
            rx_sel_b_reg <= dcm_pkg::SEL_RESET;
        end else begin
            if (wr_tx_a) tx_sel_a_reg <= wr_sel;
            if (wr_rx_a) rx_sel_a_reg <= wr_sel;
            if (wr_tx_b) tx_sel_b_reg <= wr_sel;
            if (wr_rx_b) rx_sel_b_reg <= wr_sel;
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    // Unmapped offsets read zero; bits 7..5 of selects read zero
    assign rd_data_next =
        (addr == dcm_pkg::TX_MONITOR_SELECT_A_OFS) ? {3'h0, tx_sel_a_reg} :
        (addr == dcm_pkg::TX_MONITOR_DATA_A_OFS) ? tx_snap_a :
        (addr == dcm_pkg::RX_MONITOR_SELECT_A_OFS) ? {3'h0, rx_sel_a_reg} :
        (addr == dcm_pkg::RX_MONITOR_DATA_A_OFS) ? rx_snap_a :
        (addr == dcm_pkg::TX_MONITOR_SELECT_B_OFS) ? {3'h0, tx_sel_b_reg} :
        (addr == dcm_pkg::TX_MONITOR_DATA_B_OFS) ? tx_snap_b :
        (addr == dcm_pkg::RX_MONITOR_SELECT_B_OFS) ? {3'h0, rx_sel_b_reg} :
        (addr == dcm_pkg::RX_MONITOR_DATA_B_OFS) ? rx_snap_b : 8'h00;

    // Read data lands one clock after the strobe and then holds
    always_ff @(posedge clk) begin
        if (reset) begin
            rd_data <= dcm_pkg::RDATA_RESET;
        end else if (ce && rd_en) begin
            rd_data <= rd_data_next;
        end
    end

    // ----------------------------------------
    // Path monitors
    // ----------------------------------------
    // Transmit side sees backplane data before it heads to the line
    dcm_path_monitor u_tx_a (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .bit_valid(tx_a_bit_valid),
        .bit_in(tx_a_bit),
        .frame_sync(tx_a_frame_sync),
        .chan_sel(tx_sel_a_reg),
        .replace_mask(tx_a_replace_mask),
        .replace_code(tx_a_replace_code),
        .snapshot(tx_snap_a),
        .out_bit(tx_a_out_bit),
        .out_valid(tx_a_out_valid)
    );

    // Receive side sees line data before it heads to the backplane
    dcm_path_monitor u_rx_a (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .bit_valid(rx_a_bit_valid),
        .bit_in(rx_a_bit),
        .frame_sync(rx_a_frame_sync),
        .chan_sel(rx_sel_a_reg),
        .replace_mask(rx_a_replace_mask),
        .replace_code(rx_a_replace_code),
        .snapshot(rx_snap_a),
        .out_bit(rx_a_out_bit),
        .out_valid(rx_a_out_valid)
    );

    // Framer B transmit
    dcm_path_monitor u_tx_b (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .bit_valid(tx_b_bit_valid),
        .bit_in(tx_b_bit),
        .frame_sync(tx_b_frame_sync),
        .chan_sel(tx_sel_b_reg),
        .replace_mask(tx_b_replace_mask),
        .replace_code(tx_b_replace_code),
        .snapshot(tx_snap_b),
        .out_bit(tx_b_out_bit),
        .out_valid(tx_b_out_valid)
    );

    // Framer B receive
    dcm_path_monitor u_rx_b (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .bit_valid(rx_b_bit_valid),
        .bit_in(rx_b_bit),
        .frame_sync(rx_b_frame_sync),
        .chan_sel(rx_sel_b_reg),
        .replace_mask(rx_b_replace_mask),
        .replace_code(rx_b_replace_code),
        .snapshot(rx_snap_b),
        .out_bit(rx_b_out_bit),
        .out_valid(rx_b_out_valid)
    );

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    AST_SEL_WRITE: assert property (@(posedge clk) disable iff (reset)
        wr_tx_a |=> tx_sel_a_reg == $past(wr_sel))
        else $error("transmit select A not written from bits 4..0");
    AST_SEL_B_WRITE: assert property (@(posedge clk) disable iff (reset)
        wr_rx_b |=> rx_sel_b_reg == $past(wr_sel))
        else $error("receive select B not written");
    AST_RX_SEL_WRITE: assert property (@(posedge clk) disable iff (reset)
        wr_rx_a |=> rx_sel_a_reg == $past(wr_sel))
        else $error("receive select A not written");
    AST_TX_B_WRITE: assert property (@(posedge clk) disable iff (reset)
        wr_tx_b |=> tx_sel_b_reg == $past(wr_sel))
        else $error("transmit select B not written");
    AST_SEL_READ: assert property (@(posedge clk) disable iff (reset)
        (ce && rd_en && addr == dcm_pkg::RX_MONITOR_SELECT_A_OFS) |=> rd_data == {3'h0, $past(rx_sel_a_reg)})
        else $error("receive select A read wrong");
    AST_CE_HOLD: assert property (@(posedge clk) disable iff (reset)
        !ce |=> $stable(rd_data))
        else $error("read data moved while clock enable low");
    AST_SNAP_READ: assert property (@(posedge clk) disable iff (reset)
        (ce && rd_en && addr == dcm_pkg::RX_MONITOR_DATA_A_OFS) |=> rd_data == $past(rx_snap_a))
        else $error("receive snapshot A read wrong");
    AST_TX_READ: assert property (@(posedge clk) disable iff (reset)
        (ce && rd_en && addr == dcm_pkg::TX_MONITOR_DATA_A_OFS) ##1 !rd_en [*2] |-> $stable(rd_data))
        else $error("read data did not hold");
    AST_RO_SNAP: assert property (@(posedge clk) disable iff (reset)
        (ce && wr_en && addr == dcm_pkg::TX_MONITOR_DATA_B_OFS) |=> $stable(tx_sel_b_reg))
        else $error("write to snapshot disturbed state");

    COV_RD_SNAP: cover property (@(posedge clk) disable iff (reset)
        ce && rd_en && addr == dcm_pkg::RX_MONITOR_DATA_B_OFS);
    COV_WR_SEL: cover property (@(posedge clk) disable iff (reset) wr_tx_b);

endmodule

// *** dcm_ds0_monitor_tb_top.sv ***
// Self-checking bench for the DS0 channel monitor, register port and four paths.
// Assumes one 10 MHz clock and frame sources from dcm_frame_src.
`timescale 1ns/1ns
`define DCM_CHK(got, exp) begin checks++; if ((got) !== (exp)) begin n_fail++; \
    $display("Error t=%0t got=%h exp=%h", $time, got, exp); end end
module dcm_ds0_monitor_tb_top;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic clk = 1'b0, reset = 1'b1, ce = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
    logic [7:0] addr = 8'h00, wr_data = 8'h00, rd_data, d;
    logic tx_a_bit_valid, tx_a_bit, tx_a_frame_sync, tx_a_out_bit, tx_a_out_valid;
    logic rx_a_bit_valid, rx_a_bit, rx_a_frame_sync, rx_a_out_bit, rx_a_out_valid;
    logic tx_b_bit_valid, tx_b_bit, tx_b_frame_sync, tx_b_out_bit, tx_b_out_valid;
    logic rx_b_bit_valid, rx_b_bit, rx_b_frame_sync, rx_b_out_bit, rx_b_out_valid;
    logic [23:0] tx_a_replace_mask = 24'h0, rx_a_replace_mask = 24'h0;
    logic [23:0] tx_b_replace_mask = 24'h0, rx_b_replace_mask = 24'h0;
    logic [7:0] tx_a_replace_code = 8'h00, rx_a_replace_code = 8'h00;
    logic [7:0] tx_b_replace_code = 8'h00, rx_b_replace_code = 8'h00;
    logic [192:0] tx_a_seen;
    logic [7:0] sel_ofs[4] = '{8'h19, 8'h1e, 8'hb9, 8'hbe};
    logic [7:0] snap_ofs[4] = '{8'h1a, 8'h1f, 8'hba, 8'hbf};
    logic [4:0] sel_val[4] = '{5'h05, 5'h0e, 5'h00, 5'h17};
    logic [7:0] base[4] = '{8'h10, 8'h40, 8'h70, 8'ha0};
    int tx_a_pos = 0, n_fail = 0, checks = 0;
    int n_out[4] = '{0, 0, 0, 0};
    int n_one[4] = '{0, 0, 0, 0};
    int n_prev = 0;
    logic [3:0] out_v, out_b;

    // ----------------------------------------
    // Design and far-side sources
    // ----------------------------------------
    dcm_ds0_monitor dcm_ds0_monitor_i (.clk, .reset, .ce, .addr, .wr_en, .rd_en, .wr_data, .rd_data,
        .tx_a_bit_valid, .tx_a_bit, .tx_a_frame_sync, .tx_a_replace_mask, .tx_a_replace_code,
        .tx_a_out_bit, .tx_a_out_valid, .rx_a_bit_valid, .rx_a_bit, .rx_a_frame_sync,
        .rx_a_replace_mask, .rx_a_replace_code, .rx_a_out_bit, .rx_a_out_valid,
        .tx_b_bit_valid, .tx_b_bit, .tx_b_frame_sync, .tx_b_replace_mask, .tx_b_replace_code,
        .tx_b_out_bit, .tx_b_out_valid, .rx_b_bit_valid, .rx_b_bit, .rx_b_frame_sync,
        .rx_b_replace_mask, .rx_b_replace_code, .rx_b_out_bit, .rx_b_out_valid);
    dcm_frame_src tx_a_src (.clk, .bit_valid(tx_a_bit_valid), .line_bit(tx_a_bit), .frame_sync(tx_a_frame_sync));
    dcm_frame_src rx_a_src (.clk, .bit_valid(rx_a_bit_valid), .line_bit(rx_a_bit), .frame_sync(rx_a_frame_sync));
    dcm_frame_src tx_b_src (.clk, .bit_valid(tx_b_bit_valid), .line_bit(tx_b_bit), .frame_sync(tx_b_frame_sync));
    dcm_frame_src rx_b_src (.clk, .bit_valid(rx_b_bit_valid), .line_bit(rx_b_bit), .frame_sync(rx_b_frame_sync));

    // Clock, 100 ns period
    initial begin
        forever #50 clk = ~clk;
    end

    // Output collector for transmit path A; count restarts on the F bit
    always @(posedge clk) begin
        if (tx_a_out_valid) begin
            tx_a_seen[tx_a_pos] <= tx_a_out_bit;
            tx_a_pos <= tx_a_pos + 1;
        end
        if (tx_a_bit_valid && tx_a_frame_sync) begin
            tx_a_pos <= 0;
        end
    end

    // Tally per path of output pulses and ones, so every path output is checked
    assign out_v = {rx_b_out_valid, tx_b_out_valid, rx_a_out_valid, tx_a_out_valid};
    assign out_b = {rx_b_out_bit, tx_b_out_bit, rx_a_out_bit, tx_a_out_bit};
    always @(posedge clk) begin
        for (int p = 0; p < 4; p++) begin
            if (out_v[p]) begin
                n_out[p] <= n_out[p] + 1;
                n_one[p] <= n_one[p] + int'(out_b[p]);
            end
        end
    end

    // ----------------------------------------
    // Register port tasks and helpers
    // ----------------------------------------
    task automatic reg_write(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wr_data <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    // Data is sampled once the taking edge has settled
    task automatic reg_read(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 v = rd_data;
    endtask

    // One frame on every path at once, two of them with gaps between bits
    task automatic all_frames();
        fork
            tx_a_src.send_frame(base[0], 0);
            rx_a_src.send_frame(base[1], 2);
            tx_b_src.send_frame(base[2], 2);
            rx_b_src.send_frame(base[3], 0);
        join
        repeat (2) @(posedge clk);
    endtask

    // Slot c as seen at the transmit A output, first bit in the MSB
    function automatic logic [7:0] out_byte(input int c);
        logic [7:0] b;
        for (int j = 0; j < 8; j++) begin
            b[7 - j] = tx_a_seen[8 * c + 1 + j];
        end
        return b;
    endfunction

    // Ones in one unreplaced frame, F bit sent as one
    function automatic int frame_ones(input logic [7:0] b);
        int n = 1;
        for (int k = 0; k < 24; k++) begin
            n += $countones(tx_a_src.chan_byte(b, k));
        end
        return n;
    endfunction

    task automatic stop_test();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Watchdog, well beyond the fewer than two thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        stop_test();
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            reg_read(sel_ofs[i], d);
            `DCM_CHK(d, 8'h00)
            reg_read(snap_ofs[i], d);
            `DCM_CHK(d, 8'h00)
        end
        reg_read(8'h20, d);
        `DCM_CHK(d, 8'h00)
        $display("test reset_values done");
        // Upper bits written high must read back as zero
        for (int i = 0; i < 4; i++) begin
            reg_write(sel_ofs[i], {3'h7, sel_val[i]});
            reg_read(sel_ofs[i], d);
            `DCM_CHK(d, {3'h0, sel_val[i]})
            reg_write(snap_ofs[i], 8'ha5);
            reg_read(snap_ofs[i], d);
            `DCM_CHK(d, 8'h00)
        end
        $display("test select_access done");
        // Slots 6, 15, 1 and 24 on the four paths
        all_frames();
        for (int i = 0; i < 4; i++) begin
            reg_read(snap_ofs[i], d);
            `DCM_CHK(d, tx_a_src.chan_byte(base[i], int'(sel_val[i])))
        end
        for (int i = 0; i < 4; i++) begin
            `DCM_CHK(n_out[i], 32'hc1)
            `DCM_CHK(n_one[i], frame_ones(base[i]))
        end
        $display("test snapshot_capture done");
        // Next frame refreshes; an out-of-range select keeps the old byte
        reg_write(8'h19, 8'h18);
        for (int i = 0; i < 4; i++) begin
            base[i] = base[i] + 8'h01;
        end
        all_frames();
        reg_read(8'h1a, d);
        `DCM_CHK(d, tx_a_src.chan_byte(base[0] - 8'h01, 5))
        for (int i = 1; i < 4; i++) begin
            reg_read(snap_ofs[i], d);
            `DCM_CHK(d, tx_a_src.chan_byte(base[i], int'(sel_val[i])))
        end
        $display("test refresh done");
        // Replace slot 6 on transmit A and slot 15 on receive A; neighbour and F bit pass unchanged
        reg_write(8'h19, 8'h05);
        tx_a_replace_mask <= 24'h000020;
        tx_a_replace_code <= 8'h3c;
        rx_a_replace_mask <= 24'h004000;
        rx_a_replace_code <= 8'hff;
        n_prev = n_one[1];
        fork
            tx_a_src.send_frame(8'h55, 1);
            rx_a_src.send_frame(8'h55, 0);
        join
        repeat (2) @(posedge clk);
        `DCM_CHK(n_one[1] - n_prev, frame_ones(8'h55) + 8 - $countones(tx_a_src.chan_byte(8'h55, 14)))
        `DCM_CHK(out_byte(5), 8'h3c)
        `DCM_CHK(out_byte(6), tx_a_src.chan_byte(8'h55, 6))
        `DCM_CHK(tx_a_seen[0], 1'b1)
        $display("test replacement done");
        // Writes are not taken while the clock enable is low
        ce <= 1'b0;
        reg_write(8'h19, 8'h07);
        ce <= 1'b1;
        reg_read(8'h19, d);
        `DCM_CHK(d, 8'h05)
        $display("test clock_enable done");
        stop_test();
    end
endmodule

// *** dcm_frame_src.sv ***
// Serial frame source standing in for one framer data path.
// Assumes the bench calls send_frame; one bit is offered per bit_valid strobe.
`timescale 1ns/1ns
module dcm_frame_src (
    // Clock
    input wire logic clk,
    // Serial path toward the monitor
    output logic bit_valid,
    output logic line_bit,
    output logic frame_sync
);
    // ----------------------------------------
    // Frame content and timing
    // ----------------------------------------
    // Distinct byte per slot, so a wrong slot never passes for the right one
    function automatic logic [7:0] chan_byte(input logic [7:0] base, input int k);
        return base + 8'(k) * 8'h0b;
    endfunction

    // Idle path at time zero; the data line carries no stale value
    initial begin
        bit_valid = 1'b0;
        frame_sync = 1'b0;
        line_bit = 1'b0;
    end

    // F bit, then 24 slots of 8 bits, first bit of a slot is its MSB
    task automatic send_frame(input logic [7:0] base, input int gap);
        logic [7:0] b;
        for (int i = 0; i < 193; i++) begin
            b = chan_byte(base, (i - 1) / 8);
            @(posedge clk);
            bit_valid <= 1'b1;
            frame_sync <= (i == 0);
            line_bit <= (i == 0) ? 1'b1 : b[7 - ((i - 1) % 8)];
            if (gap > 0) begin
                // Released line shows the inverse, never the last bit
                @(posedge clk);
                bit_valid <= 1'b0;
                frame_sync <= 1'b0;
                line_bit <= ~line_bit;
                repeat (gap - 1) @(posedge clk);
            end
        end
        if (gap == 0) begin
            @(posedge clk);
            bit_valid <= 1'b0;
            frame_sync <= 1'b0;
            line_bit <= ~line_bit;
        end
    endtask
endmodule

// *** dcm_path_monitor.sv ***
// One serial path of a framer: per-channel replacement plus a DS0 snapshot.
// Assumes bits arrive one per bit_valid strobe, frame_sync marking the F bit.
`timescale 1ns/1ns
module dcm_path_monitor (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // Incoming serial path
    input wire logic bit_valid,
    input wire logic bit_in,
    input wire logic frame_sync,
    // Configuration
    input wire logic [4:0] chan_sel,
    input wire logic [23:0] replace_mask,
    input wire logic [7:0] replace_code,
    // Results
    output logic [7:0] snapshot,
    output logic out_bit,
    output logic out_valid
);

    // ----------------------------------------
    // Bit position decode
    // ----------------------------------------
    logic [7:0] pos_reg;
    logic [6:0] shift_reg;
    logic [7:0] cur_pos;
    logic [7:0] cur_m1;
    logic [4:0] cur_chan;
    logic [2:0] cur_bit;
    logic is_fbit;
    logic step;
    logic in_sel;
    logic done;
    logic repl;
    logic code_bit;

    // Frame sync re-aligns the count on every frame, so a slip heals itself
    assign cur_pos = frame_sync ? dcm_pkg::FBIT_POS : pos_reg;
    assign cur_m1 = cur_pos - 8'h01;
    assign cur_chan = cur_m1[7:3];
    assign cur_bit = cur_m1[2:0];
    assign is_fbit = (cur_pos == dcm_pkg::FBIT_POS);
    assign step = ce && bit_valid;
    assign in_sel = !is_fbit && (cur_chan == chan_sel);
    assign done = step && in_sel && (cur_bit == dcm_pkg::LAST_BIT_IDX);
    assign repl = !is_fbit && replace_mask[cur_chan];
    assign code_bit = replace_code[dcm_pkg::LAST_BIT_IDX - cur_bit];

    // Position counter and channel assembly
    always_ff @(posedge clk) begin
        if (reset) begin
            pos_reg <= dcm_pkg::FBIT_POS;
            shift_reg <= 7'h00;
            snapshot <= dcm_pkg::SNAP_RESET;
        end else if (step) begin
            pos_reg <= (cur_pos == dcm_pkg::FRAME_LAST_POS) ? dcm_pkg::FBIT_POS : cur_pos + 8'h01;
            shift_reg <= {shift_reg[5:0], bit_in};
            if (done) begin
                snapshot <= {shift_reg, bit_in};
            end
        end
    end

    // Replaced stream, code sent MSB first
    always_ff @(posedge clk) begin
        if (reset) begin
            out_bit <= 1'b0;
            out_valid <= 1'b0;
        end else if (ce) begin
            out_valid <= bit_valid;
            if (bit_valid) begin
                out_bit <= repl ? code_bit : bit_in;
            end
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    logic [6:0] hist_reg;
    always_ff @(posedge clk) begin
        if (reset) begin
            hist_reg <= 7'h00;
        end else if (step) begin
            hist_reg <= {hist_reg[5:0], bit_in};
        end
    end

    AST_SNAP_ORDER: assert property (@(posedge clk) disable iff (reset)
        done |=> snapshot == {$past(hist_reg), $past(bit_in)})
        else $error("snapshot bit order wrong");
    AST_SNAP_HOLD: assert property (@(posedge clk) disable iff (reset)
        !done |=> $stable(snapshot))
        else $error("snapshot changed outside its slot");
    AST_BAD_SEL: assert property (@(posedge clk) disable iff (reset)
        (chan_sel > dcm_pkg::LAST_CHANNEL) |-> !done)
        else $error("snapshot taken for illegal channel");
    AST_WRAP: assert property (@(posedge clk) disable iff (reset)
        (step && cur_pos == dcm_pkg::FRAME_LAST_POS) |=> pos_reg == dcm_pkg::FBIT_POS)
        else $error("frame count did not wrap after 193 bits");
    AST_REPLACE: assert property (@(posedge clk) disable iff (reset)
        (step && repl) |=> out_valid && out_bit == $past(code_bit))
        else $error("replacement code bit wrong");
    AST_PASS: assert property (@(posedge clk) disable iff (reset)
        (step && !repl) |=> out_valid && out_bit == $past(bit_in))
        else $error("unreplaced bit altered");
    AST_SNAP_SLOT: assert property (@(posedge clk) disable iff (reset)
        done |-> cur_pos == {chan_sel, 3'h0} + 8'h08)
        else $error("snapshot not at end of selected slot");

    COV_SNAP: cover property (@(posedge clk) disable iff (reset) done);
    COV_REPL: cover property (@(posedge clk) disable iff (reset) step && repl);
    COV_WRAP: cover property (@(posedge clk) disable iff (reset) step && frame_sync);

endmodule

// *** dcm_pkg.sv ***
// Constants shared by the DS0 channel monitor design.
// Assumes one system clock; offsets are the framer's 8-bit register addresses.
package dcm_pkg;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] TX_MONITOR_SELECT_A_OFS = 8'h19;
    localparam logic [7:0] TX_MONITOR_DATA_A_OFS = 8'h1a;
    localparam logic [7:0] RX_MONITOR_SELECT_A_OFS = 8'h1e;
    localparam logic [7:0] RX_MONITOR_DATA_A_OFS = 8'h1f;
    localparam logic [7:0] TX_MONITOR_SELECT_B_OFS = 8'hb9;
    localparam logic [7:0] TX_MONITOR_DATA_B_OFS = 8'hba;
    localparam logic [7:0] RX_MONITOR_SELECT_B_OFS = 8'hbe;
    localparam logic [7:0] RX_MONITOR_DATA_B_OFS = 8'hbf;

    // ----------------------------------------
    // Field layout and reset values
    // ----------------------------------------
    localparam int SEL_MSB = 4;
    localparam int SEL_LSB = 0;
    localparam logic [4:0] SEL_RESET = 5'h00;
    localparam logic [7:0] SNAP_RESET = 8'h00;
    localparam logic [7:0] RDATA_RESET = 8'h00;

    // ----------------------------------------
    // Frame structure
    // ----------------------------------------
    localparam int CHANNEL_RATE_KBPS = 64;
    localparam int NUM_CHANNELS = 24;
    localparam logic [4:0] LAST_CHANNEL = 5'h17;
    localparam logic [7:0] FRAME_LAST_POS = 8'hc0;
    localparam logic [7:0] FBIT_POS = 8'h00;
    localparam logic [2:0] LAST_BIT_IDX = 3'h7;

endpackage
